// [verilog/gbp_pkg.sv]
// package for the eight-pin general-purpose port with boot straps
// assumes a single core clock and a synchronous active-high reset
package gbp_pkg;
	localparam int unsigned GPIO_W = 8;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	// register offsets on the plain register port
	localparam logic [3:0] OFF_DIR    = 4'h0; // pin_direction_reg
	localparam logic [3:0] OFF_DATA   = 4'h1; // pin_data_reg
	localparam logic [3:0] OFF_STRAP  = 4'h2; // captured straps, read only
	localparam logic [3:0] OFF_CLOCK_MODE_REG  = 4'h3; // clock_mode_reg
	localparam logic [3:0] OFF_FLAG   = 4'h4; // flag control
	localparam logic [3:0] OFF_BOOT   = 4'h5; // boot loader control
	// reset values
	localparam logic [7:0] DIR_RST    = 8'h00; // all inputs
	localparam logic [7:0] DATA_RST   = 8'h00;
	localparam logic       FLAG_RST   = 1'b1;
	// pin and field positions
	localparam int unsigned BOOT_LSB  = 0;
	localparam int unsigned BOOT_W    = 3;
	localparam int unsigned PIN_HS    = 4; // handshake / clock select pin
	localparam int unsigned PIN_FSEL  = 6; // multiplexed function select
	localparam int unsigned CLKSEL_B  = 0; // input_clock_select_bit
	// flag control field positions
	localparam int unsigned FL_SET_B  = 0; // bit_set_instr
	localparam int unsigned FL_CLR_B  = 1; // bit_clear_instr
	localparam int unsigned FL_ST1_B  = 2; // status_reg_one load strobe
	localparam int unsigned FL_VAL_B  = 3; // value loaded with status_reg_one
	// boot control field positions
	localparam int unsigned BT_HSEN_B = 0; // handshake drive enable
	localparam int unsigned BT_HSV_B  = 1; // handshake level
	localparam int unsigned BT_DONE_B = 2; // boot completed
	// reset sequencer states, gray along the path
	typedef enum logic [1:0] {
		GBP_RESET   = 2'b00,
		GBP_CAPTURE = 2'b01,
		GBP_BOOT    = 2'b11,
		GBP_RUN     = 2'b10
	} gbp_state_t;
endpackage

// [verilog/gbp_sync.sv]
// two-flop synchroniser for the eight port pins
// assumes pins are asynchronous to clk_sys
module gbp_sync (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [7:0] async_in,
	output logic      [7:0] sync_out
);
	logic [7:0] meta_q;

	// first stage is read only by the second stage
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q   <= 8'h00;
			sync_out <= 8'h00;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// [verilog/gbp_port.sv]
// general-purpose port: direction and data, boot straps, flag output
// assumes pads combine gpio_out/gpio_oe; registers on a plain strobe port
////////////////////////////////////////////////////////////////////////////////
// Function
// - direction bit per pin selects in/out
// - reads give pin levels, writes drive outputs
// - reset makes every pin an input
// - pins 2..0 latched as boot mode
// - pin 4 drives handshake during boot
// - pin 4 low selects oscillator clock
// - pin 4 high selects external clock
// - pin 6 selects multiplexed port function
// - flag set, cleared, loaded from status
// - flag output high during reset
//
// The plain strobed port and the placing of the registers are this design's own decisions.
module gbp_port (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic [7:0] gpio_in,
	output logic      [7:0] gpio_out,
	output logic      [7:0] gpio_oe,
	output logic      [2:0] boot_select,
	output logic            input_clock_select_bit,
	output logic            parallel_general_io_mode,
	output logic            boot_done,
	output logic            flag_output_pin
);
	logic [7:0]          pin_sync;
	logic [7:0]          dir_q;
	logic [7:0]          data_q;
	logic [2:0]          boot_q;
	logic                clksel_q;
	logic                fsel_q;
	logic                hs_en_q;
	logic                hs_val_q;
	logic                done_q;
	logic                flag_q;
	gbp_pkg::gbp_state_t state_q;
	logic                strap_take;
	logic                take_q;

	////////////////////////////////////////////////////////////////////////
	// pin sampling
	gbp_sync u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in (gpio_in),
		.sync_out (pin_sync)
	);

	// write decode shared by the register processes
	function automatic logic wr_hit(input logic [3:0] off);
		return reg_wr && (reg_addr == off);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reset sequencer: straps captured once, on the third edge after release
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= gbp_pkg::GBP_RESET;
		end else begin
			case (state_q)
			gbp_pkg::GBP_RESET:   state_q <= gbp_pkg::GBP_CAPTURE;
			gbp_pkg::GBP_CAPTURE: state_q <= gbp_pkg::GBP_BOOT;
			gbp_pkg::GBP_BOOT: begin
				if (done_q)
					state_q <= gbp_pkg::GBP_RUN;
			end
			gbp_pkg::GBP_RUN:     state_q <= gbp_pkg::GBP_RUN;
			default:              state_q <= gbp_pkg::GBP_RESET;
			endcase
		end
	end

	// synchroniser is held clear in reset, so its output only shows a pin
	// two edges after release; taking one cycle later avoids capturing 0
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			take_q <= 1'b0;
		end else begin
			take_q <= (state_q == gbp_pkg::GBP_CAPTURE);
		end
	end

	assign strap_take = take_q;

	////////////////////////////////////////////////////////////////////////
	// strap capture; held stable until next reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			boot_q   <= 3'h0;
			clksel_q <= 1'b0;
			fsel_q   <= 1'b0;
		end else if (strap_take) begin
			boot_q   <= pin_sync[gbp_pkg::BOOT_LSB +: gbp_pkg::BOOT_W];
			clksel_q <= pin_sync[gbp_pkg::PIN_HS];
			fsel_q   <= pin_sync[gbp_pkg::PIN_FSEL];
		end
	end

	// clock mode register: software may override the select after boot
	// (the strap value wins in the capture cycle)
	logic clock_mode_reg_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			clock_mode_reg_q <= 1'b0;
		end else if (strap_take) begin
			clock_mode_reg_q <= pin_sync[gbp_pkg::PIN_HS];
		end else if (wr_hit(gbp_pkg::OFF_CLOCK_MODE_REG)) begin
			clock_mode_reg_q <= reg_wdata[gbp_pkg::CLKSEL_B];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// direction and data registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dir_q <= gbp_pkg::DIR_RST;
		end else if (wr_hit(gbp_pkg::OFF_DIR)) begin
			dir_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			data_q <= gbp_pkg::DATA_RST;
		end else if (wr_hit(gbp_pkg::OFF_DATA)) begin
			data_q <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// boot loader handshake control, active only until boot completes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hs_en_q  <= 1'b0;
			hs_val_q <= 1'b0;
			done_q   <= 1'b0;
		end else if (wr_hit(gbp_pkg::OFF_BOOT)) begin
			hs_en_q  <= reg_wdata[gbp_pkg::BT_HSEN_B] && !done_q;
			hs_val_q <= reg_wdata[gbp_pkg::BT_HSV_B];
			// done is sticky: once set, only reset returns to boot
			done_q   <= done_q || reg_wdata[gbp_pkg::BT_DONE_B];
		end else if (done_q) begin
			hs_en_q  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flag output: set, clear or status load; status load tested before set and clear
	// so a simultaneous status load takes priority over both
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flag_q <= gbp_pkg::FLAG_RST;
		end else if (wr_hit(gbp_pkg::OFF_FLAG)) begin
			if (reg_wdata[gbp_pkg::FL_ST1_B])
				flag_q <= reg_wdata[gbp_pkg::FL_VAL_B];
			else if (reg_wdata[gbp_pkg::FL_SET_B])
				flag_q <= 1'b1;
			else if (reg_wdata[gbp_pkg::FL_CLR_B])
				flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers registered so outputs come from flip-flops
	// handshake overrides pin 4 while the loader owns it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gpio_oe  <= 8'h00;
			gpio_out <= 8'h00;
		end else begin
			gpio_oe  <= dir_q;
			gpio_out <= data_q;
			if (hs_en_q) begin
				gpio_oe[gbp_pkg::PIN_HS]  <= 1'b1;
				gpio_out[gbp_pkg::PIN_HS] <= hs_val_q;
			end
		end
	end

	// strap outputs and status pins
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			boot_select              <= 3'h0;
			input_clock_select_bit   <= 1'b0;
			parallel_general_io_mode <= 1'b0;
			boot_done                <= 1'b0;
			flag_output_pin          <= gbp_pkg::FLAG_RST;
		end else begin
			boot_select              <= boot_q;
			input_clock_select_bit   <= clock_mode_reg_q;
			parallel_general_io_mode <= fsel_q;
			boot_done                <= (state_q == gbp_pkg::GBP_RUN);
			flag_output_pin          <= flag_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			gbp_pkg::OFF_DIR:   reg_rdata <= dir_q;
			// inputs show pin level, outputs show the driven value
			gbp_pkg::OFF_DATA:  reg_rdata <= (pin_sync & ~dir_q)
			                              | (data_q & dir_q);
			gbp_pkg::OFF_STRAP: reg_rdata <= {1'b0, fsel_q, 1'b0, clksel_q,
			                              1'b0, boot_q};
			gbp_pkg::OFF_CLOCK_MODE_REG: reg_rdata <= {7'h00, clock_mode_reg_q};
			gbp_pkg::OFF_FLAG:  reg_rdata <= {4'h0, flag_q, 3'h0};
			gbp_pkg::OFF_BOOT:  reg_rdata <= {5'h00, done_q, hs_val_q,
			                              hs_en_q};
			default:            reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule

// [verif/gbp_board.sv]
// board side of the port: strap resistors and external pin drivers
// assumes the bench sets the level of every released pin through strap
module gbp_board (
	input  wire logic [7:0] strap,
	input  wire logic [7:0] gpio_out,
	input  wire logic [7:0] gpio_oe,
	output wire logic [7:0] gpio_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// released pins fall to the resistors, never to a stale drive
	assign gpio_in = (gpio_out & gpio_oe) | (strap & ~gpio_oe);
endmodule

// [verif/gbp_port_assertions.sv]
// checker for the general-purpose port, bound to every gbp_port
// assumes one clock and a synchronous active-high reset
module gbp_port_checker (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] gpio_in,
	input wire logic [7:0] gpio_out,
	input wire logic [7:0] gpio_oe,
	input wire logic [2:0] boot_select,
	input wire logic       input_clock_select_bit,
	input wire logic       parallel_general_io_mode,
	input wire logic       boot_done,
	input wire logic       flag_output_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_q;
	logic       dn_q;
	wire        wr_dir = reg_wr && reg_addr == gbp_pkg::OFF_DIR;
	wire        wr_dat = reg_wr && reg_addr == gbp_pkg::OFF_DATA;
	wire        wr_flg = reg_wr && reg_addr == gbp_pkg::OFF_FLAG;
	wire        wr_hs  = reg_wr && reg_addr == gbp_pkg::OFF_BOOT
		&& reg_wdata[0] && !reg_wdata[2] && !boot_done && !dn_q;
	// boot_done lags the done write, so track the write itself
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dn_q <= 1'b0;
		end else if (reg_wr && reg_addr == gbp_pkg::OFF_BOOT
			&& reg_wdata[2]) begin
			dn_q <= 1'b1;
		end
	end
	// straps settle some cycles after release, so count them
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cnt_q <= 3'h0;
		end else if (cnt_q != 3'h7) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// pin 4 is masked in the direction and data checks: the boot handshake may own it
	a_oe_reset: assert property ($past(rst) |-> gpio_oe == 8'h00)
		else $error("pins driven after reset");
	a_flag_reset: assert property ($past(rst) |-> flag_output_pin)
		else $error("flag low after reset");
	a_dir_drive: assert property (wr_dir |-> ##2
		((gpio_oe ^ $past(reg_wdata, 2)) & 8'hEF) == 8'h00)
		else $error("direction not applied");
	a_data_drive: assert property (wr_dat |-> ##2
		((gpio_out ^ $past(reg_wdata, 2)) & gpio_oe & 8'hEF) == 8'h00)
		else $error("data not driven");
	a_strap_capture: assert property (cnt_q == 3'h2 |-> ##4
		{boot_select, input_clock_select_bit, parallel_general_io_mode}
		== $past({gpio_in[2:0], gpio_in[4], gpio_in[6]}, 4))
		else $error("strap capture wrong");
	a_strap_hold: assert property (cnt_q == 3'h7 |->
		$stable(boot_select) && $stable(parallel_general_io_mode))
		else $error("strap changed");
	a_hs_drive: assert property (wr_hs |-> ##2 gpio_oe[4]
		&& gpio_out[4] == $past(reg_wdata[1], 2))
		else $error("handshake not driven");
	a_flag_set: assert property (wr_flg && reg_wdata[2:0] == 3'h1
		|-> ##[1:2] flag_output_pin) else $error("flag not set");
	a_flag_clear: assert property (wr_flg && reg_wdata[2:0] == 3'h2
		|-> ##[1:2] !flag_output_pin) else $error("flag not cleared");
	c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
	c_boot: cover property ($rose(boot_done));
	c_flag: cover property ($fell(flag_output_pin));
endmodule
bind gbp_port gbp_port_checker chk (.*);

// [verif/gbp_port_test.sv]
// bench for the general-purpose port with boot straps
// assumes the board model beside the dut and the bound checker
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module gbp_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] strap = 8'h00;
	logic [7:0] reg_rdata, gpio_in, gpio_out, gpio_oe, s, d, v;
	logic [2:0] boot_sel;
	logic       clk_sel, pgio, boot_done, flag, f;
	logic [7:0] fl_w [6] = '{8'h02, 8'h01, 8'h04, 8'h0C, 8'h05, 8'h03};
	int         mismatches = 0;
	int         num_checks = 0;
	always #4 clk_sys = ~clk_sys;
	gbp_port dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .gpio_in(gpio_in), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .boot_select(boot_sel),
		.input_clock_select_bit(clk_sel), .parallel_general_io_mode(pgio),
		.boot_done(boot_done), .flag_output_pin(flag));
	gbp_board board (.strap(strap), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.gpio_in(gpio_in));
	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] exp_pins(logic [7:0] dr, vl, st);
		return (vl & dr) | (st & ~dr);
	endfunction
	function automatic logic exp_flag(logic [7:0] w, logic p);
		return w[2] ? w[3] : w[0] ? 1'b1 : w[1] ? 1'b0 : p;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] x);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	// straps stay put across the whole reset and a few cycles after
	task automatic reset(input int n, input logic [7:0] x);
		strap = x;
		rst <= 1'b1;
		tick(n);
		`CHK({flag, gpio_oe}, 9'h100)
		rst <= 1'b0;
		tick(7);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// main sequence: straps, boot handshake, random port, flag
	initial begin
		void'($urandom(96351));
		for (int i = 0; i < 2; i++) begin
			s = (8'($urandom()) & 8'h6F) | {3'h0, i[0], 4'h0};
			reset(i ? 2 : 20, s);
			`CHK({boot_sel, clk_sel, pgio}, {s[2:0], s[4], s[6]})
			rd(gbp_pkg::OFF_STRAP, s & 8'h57);
			rd(gbp_pkg::OFF_CLOCK_MODE_REG, {7'h00, s[4]});
			strap = 8'($urandom());
			tick(3);
			`CHK({boot_sel, pgio}, {s[2:0], s[6]})
			$display("test reset %0d done", i);
		end
		wr(gbp_pkg::OFF_BOOT, 8'h03);
		tick(2);
		`CHK({gpio_oe[4], gpio_out[4]}, 2'b11)
		wr(gbp_pkg::OFF_BOOT, 8'h01);
		tick(2);
		`CHK({gpio_oe[4], gpio_out[4]}, 2'b10)
		wr(gbp_pkg::OFF_BOOT, 8'h04);
		wr(gbp_pkg::OFF_BOOT, 8'h03);
		tick(2);
		`CHK({boot_done, gpio_oe[4]}, 2'b10)
		$display("test boot done");
		for (int i = 0; i < 12; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom());
			v = 8'($urandom());
			s = 8'($urandom());
			strap = s;
			wr(gbp_pkg::OFF_DIR, d);
			wr(gbp_pkg::OFF_DATA, v);
			tick(3);
			`CHK(gpio_oe, d)
			`CHK(gpio_out & d, v & d)
			rd(gbp_pkg::OFF_DIR, d);
			rd(gbp_pkg::OFF_DATA, exp_pins(d, v, s));
		end
		rd(4'hF, 8'h00);
		$display("test port done");
		f = 1'b1;
		foreach (fl_w[j]) begin
			wr(gbp_pkg::OFF_FLAG, fl_w[j]);
			tick(2);
			f = exp_flag(fl_w[j], f);
			`CHK(flag, f)
		end
		$display("test flag done");
		end_sim();
	end
	// a hang costs a mismatch and ends the run the usual way
	initial begin
		repeat (3000) @(posedge clk_sys);
		mismatches++;
		end_sim();
	end
endmodule
